// >>> design/cits_seq.sv
// Interrupt entry, return, single-step and reset sequencer
`timescale 1ns/100ps
`include "cits_cfg.svh"
module cits_seq
  import cits_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Instruction boundary events from execution
  input wire logic INSTR_DONE,
  input wire logic INSTR_STI,
  input wire logic INSTR_CLI,
  input wire logic INSTR_IRQ_RETURN_INSTR,
  input wire logic INSTR_POP_FLAGS_INSTR,
  input wire logic [15:0] POP_FLAGS_INSTR_DATA,
  input wire logic SOFT_REQ,
  input wire logic [7:0] SOFT_VEC,
  input wire logic [7:0] OPCODE,
  // External requests
  input wire logic NMI_REQ,
  input wire logic MASKABLE_REQUEST,
  input wire logic [7:0] MASKABLE_REQUEST_VEC,
  // Memory word port
  output logic MEM_REQ,
  output logic MEM_WR,
  output logic [19:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA,
  // Architectural state
  output logic [15:0] FLAGS,
  output logic [15:0] INSTRUCTION_POINTER_REG,
  output logic [15:0] CODE_SEGMENT_REG,
  output logic [15:0] DATA_SEGMENT_REG,
  output logic [15:0] STACK_SEGMENT_REG,
  output logic [15:0] EXTRA_SEGMENT_REG,
  output logic [15:0] STACK_PTR,
  output logic QUEUE_FLUSH,
  output logic [19:0] FETCH_ADDR,
  output logic IN_SEQ,
  output logic [7:0] ACTIVE_VEC
);
  cits_state_e state_q, state_d;
  logic [15:0] flags_q, ip_q, cs_q, sp_q, ds_q, ss_q, es_q;
  logic [15:0] saved_flags_q;
  logic [7:0] vec_q;
  logic nmi_d1_q, nmi_pend_q, step_arm_q;
  logic flush_q;
  cits_src_e src;
  logic [7:0] arb_vec;
  wire trap_flag = flags_q[`CITS_TF_BIT];
  wire irq_en = flags_q[`CITS_IF_BIT];
  wire at_boundary = (state_q == ST_RUN) && INSTR_DONE;
  wire vec_done = (state_q == ST_VEC_CS) && MEM_ACK;
  // Enable instruction delays maskable acceptance by one instruction
  wire maskable_request_ok = MASKABLE_REQUEST && irq_en && !(at_boundary && INSTR_STI);
  // Old flag image decides at a flag-loading boundary, so the trap comes one later
  wire step_ok = trap_flag && step_arm_q;
  // Entry made while stepping chains a step entry before the handler runs
  wire step_chain = vec_done && saved_flags_q[`CITS_TF_BIT] &&
                    (vec_q != `CITS_VEC_STEP);
  wire soft_now = at_boundary && (SOFT_REQ || OPCODE == `CITS_OP_BRK);
  wire [7:0] soft_vec_now = (OPCODE == `CITS_OP_BRK) ? `CITS_VEC_BRK : SOFT_VEC;
  wire nmi_edge = NMI_REQ && !nmi_d1_q;
  wire take = (at_boundary && !INSTR_IRQ_RETURN_INSTR) && (src != SRC_NONE);
  wire [15:0] sp_dec = sp_q - `CITS_SP_STEP;
  wire [19:0] stk_addr = {ss_q, 4'h0} + {4'h0, sp_q};
  wire [19:0] stk_push_addr = {ss_q, 4'h0} + {4'h0, sp_dec};
  wire [19:0] vec_base = {10'h000, vec_q, 2'b00};

  cits_req_arb u_arb (
    .soft_pend(soft_now),
    .soft_vec(soft_vec_now),
    .nmi_pend(nmi_pend_q || nmi_edge),
    .maskable_request_ok(maskable_request_ok),
    .maskable_request_vec(MASKABLE_REQUEST_VEC),
    .step_ok(step_ok),
    .src(src),
    .vec(arb_vec)
  );

  // Next state of entry and return sequence
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
        if (at_boundary && INSTR_IRQ_RETURN_INSTR)
          state_d = ST_POP_IP;
        else if (take)
          state_d = ST_PUSH_F;
      ST_PUSH_F: if (MEM_ACK) state_d = ST_PUSH_CS;
      ST_PUSH_CS: if (MEM_ACK) state_d = ST_PUSH_IP;
      ST_PUSH_IP: if (MEM_ACK) state_d = ST_VEC_IP;
      ST_VEC_IP: if (MEM_ACK) state_d = ST_VEC_CS;
      ST_VEC_CS: if (MEM_ACK) state_d = step_chain ? ST_PUSH_F : ST_RUN;
      ST_POP_IP: if (MEM_ACK) state_d = ST_POP_CS;
      ST_POP_CS: if (MEM_ACK) state_d = ST_POP_F;
      ST_POP_F: if (MEM_ACK) state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  // Memory port decode
  assign MEM_REQ = (state_q != ST_RUN);
  assign MEM_WR = (state_q == ST_PUSH_F) || (state_q == ST_PUSH_CS) ||
                  (state_q == ST_PUSH_IP);
  assign MEM_ADDR = MEM_WR ? stk_push_addr :
                    (state_q == ST_VEC_IP) ? vec_base :
                    (state_q == ST_VEC_CS) ? vec_base + 20'h00002 : stk_addr;
  assign MEM_WDATA = (state_q == ST_PUSH_F) ? saved_flags_q :
                     (state_q == ST_PUSH_CS) ? cs_q : ip_q;

  // Sequencer state, vector and flags
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q <= ST_RUN;
      flags_q <= `CITS_RST_FLAGS;
      saved_flags_q <= `CITS_RST_FLAGS;
      vec_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if ((state_q == ST_RUN && state_d == ST_PUSH_F) || step_chain)
      begin
        vec_q <= step_chain ? `CITS_VEC_STEP : arb_vec;
        saved_flags_q <= flags_q;
        flags_q <= flags_q & `CITS_TF_CLR_MASK & ~`CITS_IF_MASK;
      end
      else if (state_q == ST_POP_F && MEM_ACK)
        flags_q <= MEM_RDATA;
      else if (at_boundary && INSTR_POP_FLAGS_INSTR && !take)
        flags_q <= POP_FLAGS_INSTR_DATA;
      else if (at_boundary && !take && (INSTR_STI || INSTR_CLI))
        flags_q[`CITS_IF_BIT] <= INSTR_STI;
    end
  end

  // Pointer, segments and stack pointer
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ip_q <= `CITS_RST_IP;
      cs_q <= `CITS_RST_CS;
      ds_q <= `CITS_RST_SEG;
      ss_q <= `CITS_RST_SEG;
      es_q <= `CITS_RST_SEG;
      sp_q <= `CITS_RST_SEG;
    end
    else if (MEM_ACK)
    begin
      if (MEM_WR)
        sp_q <= sp_dec;
      else if (state_q == ST_POP_IP || state_q == ST_POP_CS || state_q == ST_POP_F)
        sp_q <= sp_q + `CITS_SP_STEP;
      if (state_q == ST_VEC_IP || state_q == ST_POP_IP)
        ip_q <= MEM_RDATA;
      if (state_q == ST_VEC_CS || state_q == ST_POP_CS)
        cs_q <= MEM_RDATA;
    end
  end

  // Request latches, step arming and queue flush
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      nmi_d1_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      step_arm_q <= 1'b0;
      flush_q <= 1'b1;
    end
    else
    begin
      nmi_d1_q <= NMI_REQ;
      // Latched edge; new edge wins over clear
      if (nmi_edge)
        nmi_pend_q <= 1'b1;
      else if (take && src == SRC_NMI)
        nmi_pend_q <= 1'b0;
      // Arm once the first instruction after reset has completed
      if (at_boundary)
        step_arm_q <= 1'b1;
      flush_q <= (state_q != ST_RUN) && (state_d == ST_RUN);
    end
  end

  // Outputs
  assign FLAGS = flags_q;
  assign INSTRUCTION_POINTER_REG = ip_q;
  assign CODE_SEGMENT_REG = cs_q;
  assign DATA_SEGMENT_REG = ds_q;
  assign STACK_SEGMENT_REG = ss_q;
  assign EXTRA_SEGMENT_REG = es_q;
  assign STACK_PTR = sp_q;
  assign QUEUE_FLUSH = flush_q;
  assign FETCH_ADDR = {cs_q, 4'h0} + {4'h0, ip_q};
  assign IN_SEQ = (state_q != ST_RUN);
  assign ACTIVE_VEC = vec_q;
endmodule

// >>> design/cits_cfg.svh
// Constants for the interrupt, trap and reset sequencer
// Overview of operation
// - Interrupt entry pushes flags, code segment, pointer; clears trap and enable flags.
// - After enable instruction, maskable requests wait one further completed instruction.
// - Non-maskable request preempts any handler regardless of enable flag.
// - Software interrupts and exceptions inside a handler are taken at once, nesting.
// - Return pops pointer, code segment, flags, then resumes at restored location.
// - With trap flag set, vector 1 is raised after each instruction.
// - Trap flag restored by return first traps after the next instruction.
// - Trap flag is flag bit mask 0100H, clear mask FEFFH, changed by flag loads.
// - No instruction sets or clears the trap flag directly.
// - Single-stepping, another interrupt enters normally, then vector 1 before first handler instruction.
// - Vector 3 is breakpoint; single-byte opcode CCH.
// - Reset high halts all activity; on release the state initializes. The code resets while RSTN is low and loads the state at once.
// - Reset clears flags, pointer 0000H, code FFFFH, data/stack/extra 0000H, queue empty.
// - First fetch after reset is from physical address FFFF0H.
// - Dispatch reads two-word vector; second word to code segment, first to pointer.
// - Priority: exceptions/software, then non-maskable, then maskable, then single-step.
`ifndef CITS_CFG_SVH
`define CITS_CFG_SVH
`define CITS_TF_MASK 16'h0100
`define CITS_TF_CLR_MASK 16'hfeff
`define CITS_IF_MASK 16'h0200
`define CITS_TF_BIT 8
`define CITS_IF_BIT 9
`define CITS_RST_FLAGS 16'h0000
`define CITS_RST_IP 16'h0000
`define CITS_RST_CS 16'hffff
`define CITS_RST_SEG 16'h0000
`define CITS_VEC_STEP 8'h01
`define CITS_VEC_NMI 8'h02
`define CITS_VEC_BRK 8'h03
`define CITS_OP_BRK 8'hcc
`define CITS_SP_STEP 16'h0002
`endif

// >>> design/cits_pkg.sv
// Types for the interrupt, trap and reset sequencer
package cits_pkg;
  typedef enum {ST_RUN, ST_PUSH_F, ST_PUSH_CS, ST_PUSH_IP, ST_VEC_IP, ST_VEC_CS,
    ST_POP_IP, ST_POP_CS, ST_POP_F} cits_state_e;
  typedef enum {SRC_NONE, SRC_SOFT, SRC_NMI, SRC_MASKABLE_REQUEST, SRC_STEP} cits_src_e;
endpackage

// >>> design/cits_req_arb.sv
// Priority selection among pending interrupt sources
`timescale 1ns/100ps
`include "cits_cfg.svh"
module cits_req_arb
  import cits_pkg::*;
(
  // Pending sources
  input wire logic soft_pend,
  input wire logic [7:0] soft_vec,
  input wire logic nmi_pend,
  input wire logic maskable_request_ok,
  input wire logic [7:0] maskable_request_vec,
  input wire logic step_ok,
  // Selection
  output cits_src_e src,
  output logic [7:0] vec
);
  // Fixed priority pick
  assign src = soft_pend ? SRC_SOFT : nmi_pend ? SRC_NMI :
               maskable_request_ok ? SRC_MASKABLE_REQUEST : step_ok ? SRC_STEP : SRC_NONE;
  assign vec = soft_pend ? soft_vec : nmi_pend ? `CITS_VEC_NMI :
               maskable_request_ok ? maskable_request_vec : `CITS_VEC_STEP;
endmodule

// >>> tb/cits_seq_props.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/100ps
module cits_seq_chk
  import cits_pkg::*;
(
  // Clock, reset and boundary events
  input wire logic CLK, RSTN, INSTR_DONE, SOFT_REQ,
  input wire logic [7:0] SOFT_VEC, OPCODE, ACTIVE_VEC,
  // Memory port and state
  input wire logic MEM_REQ, MEM_WR, MEM_ACK, IN_SEQ, QUEUE_FLUSH,
  input wire logic [19:0] MEM_ADDR, FETCH_ADDR,
  input wire logic [15:0] MEM_WDATA, MEM_RDATA, FLAGS, STACK_PTR, STACK_SEGMENT_REG,
  input wire logic [15:0] INSTRUCTION_POINTER_REG, CODE_SEGMENT_REG, DATA_SEGMENT_REG,
  input wire logic [15:0] EXTRA_SEGMENT_REG
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // --------------------------------
  // Reset, entry and word checks
  // --------------------------------
  rst_state_a: assert property ($rose(RSTN) |-> QUEUE_FLUSH && !FLAGS
    && CODE_SEGMENT_REG == 16'hffff && 64'h0 == {INSTRUCTION_POINTER_REG,
    DATA_SEGMENT_REG, STACK_SEGMENT_REG, EXTRA_SEGMENT_REG}) else $error("bad reset state");
  fetch_addr_a: assert property (!IN_SEQ |-> FETCH_ADDR == {CODE_SEGMENT_REG, 4'h0}
    + {4'h0, INSTRUCTION_POINTER_REG}) else $error("fetch address wrong");
  flags_push_a: assert property ($rose(IN_SEQ) && MEM_WR
    |-> MEM_WDATA == $past(FLAGS)) else $error("first push not flags");
  push_addr_a: assert property (MEM_REQ && MEM_WR |-> MEM_ADDR ==
    {STACK_SEGMENT_REG, 4'h0} + {4'h0, STACK_PTR - 16'h0002}) else $error("bad push address");
  entry_end_a: assert property (MEM_ACK && !MEM_WR && MEM_ADDR < 20'h00400 && MEM_ADDR[1]
    |=> !(FLAGS & 16'h0300) && CODE_SEGMENT_REG == $past(MEM_RDATA)) else $error("bad entry end");
  vec_addr_a: assert property (MEM_REQ && !MEM_WR && MEM_ADDR < 20'h00400
    |-> MEM_ADDR[9:2] == ACTIVE_VEC) else $error("vector address wrong");
  word_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR)
    && $stable(MEM_WR)) else $error("word request dropped");
  no_split_a: assert property (MEM_WR && MEM_ACK |=> IN_SEQ && MEM_REQ)
    else $error("entry split");
  soft_vec_a: assert property (INSTR_DONE && !IN_SEQ && SOFT_REQ && OPCODE != 8'hcc
    |=> IN_SEQ && ACTIVE_VEC == $past(SOFT_VEC)) else $error("soft vector wrong");
  brk_vec_a: assert property (INSTR_DONE && !IN_SEQ && SOFT_REQ && OPCODE == 8'hcc
    |=> IN_SEQ && ACTIVE_VEC == 8'h03) else $error("breakpoint vector wrong");
endmodule
bind cits_seq cits_seq_chk cits_seq_chk_inst (.CLK, .RSTN, .INSTR_DONE, .SOFT_REQ, .SOFT_VEC,
  .OPCODE, .ACTIVE_VEC, .MEM_REQ, .MEM_WR, .MEM_ACK, .IN_SEQ, .QUEUE_FLUSH, .MEM_ADDR,
  .FETCH_ADDR, .MEM_WDATA, .MEM_RDATA, .FLAGS, .STACK_PTR, .STACK_SEGMENT_REG,
  .INSTRUCTION_POINTER_REG, .CODE_SEGMENT_REG, .DATA_SEGMENT_REG, .EXTRA_SEGMENT_REG);

// >>> tb/cits_mem_mdl.sv
// Word memory answering stack and vector requests
`timescale 1ns/100ps
module cits_mem_mdl (
  // Clock, reset, answer delay
  input wire logic CLK, RSTN,
  input wire logic [3:0] dly,
  // Word port
  input wire logic MEM_REQ, MEM_WR,
  input wire logic [19:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  output logic MEM_ACK,
  output logic [15:0] MEM_RDATA
);
  logic [15:0] mem [logic [19:0]];
  logic [3:0] cnt_q;
  // Ack a held word after dly cycles; data scrambled outside acks
  always @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      MEM_ACK <= 1'b0;
      MEM_RDATA <= 16'h5a5a;
      cnt_q <= 4'h0;
    end
    else if (MEM_REQ && !MEM_ACK && cnt_q >= dly)
    begin
      MEM_ACK <= 1'b1;
      cnt_q <= 4'h0;
      if (MEM_WR)
        mem[MEM_ADDR] = MEM_WDATA;
      MEM_RDATA <= mem.exists(MEM_ADDR) ? mem[MEM_ADDR] : MEM_ADDR[15:0] + 16'h1000;
    end
    else
    begin
      MEM_ACK <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
      cnt_q <= (MEM_REQ && !MEM_ACK) ? cnt_q + 4'h1 : 4'h0;
    end
endmodule

// >>> tb/cits_seq_bench.sv
// Self-checking bench for the sequencer
`timescale 1ns/100ps
`define CK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module cits_seq_bench;
  import cits_pkg::*;
  logic CLK = 0, RSTN = 0, INSTR_DONE = 0, INSTR_STI = 0, INSTR_CLI = 0, INSTR_IRQ_RETURN_INSTR = 0;
  logic INSTR_POP_FLAGS_INSTR = 0, SOFT_REQ = 0, NMI_REQ = 0, MASKABLE_REQUEST = 0;
  logic [15:0] POP_FLAGS_INSTR_DATA = 16'h0000;
  logic [7:0] SOFT_VEC = 8'h00, OPCODE = 8'h00, MASKABLE_REQUEST_VEC = 8'h00;
  logic [3:0] dly = 4'h3;
  wire MEM_REQ, MEM_WR, MEM_ACK, QUEUE_FLUSH, IN_SEQ;
  wire [19:0] MEM_ADDR, FETCH_ADDR;
  wire [15:0] MEM_WDATA, MEM_RDATA, FLAGS, INSTRUCTION_POINTER_REG, CODE_SEGMENT_REG;
  wire [15:0] DATA_SEGMENT_REG, STACK_SEGMENT_REG, EXTRA_SEGMENT_REG, STACK_PTR;
  wire [7:0] ACTIVE_VEC;
  wire [71:0] st = {FLAGS, ACTIVE_VEC, INSTRUCTION_POINTER_REG, CODE_SEGMENT_REG, STACK_PTR};
  int n_fail = 0, n_tests = 0;
  cits_seq cits_seq_inst (.CLK, .RSTN, .INSTR_DONE, .INSTR_STI, .INSTR_CLI, .INSTR_IRQ_RETURN_INSTR,
    .INSTR_POP_FLAGS_INSTR, .POP_FLAGS_INSTR_DATA, .SOFT_REQ, .SOFT_VEC, .OPCODE, .NMI_REQ, .MASKABLE_REQUEST,
    .MASKABLE_REQUEST_VEC, .MEM_REQ, .MEM_WR, .MEM_ADDR, .MEM_WDATA, .MEM_ACK, .MEM_RDATA, .FLAGS,
    .INSTRUCTION_POINTER_REG, .CODE_SEGMENT_REG, .DATA_SEGMENT_REG, .STACK_SEGMENT_REG,
    .EXTRA_SEGMENT_REG, .STACK_PTR, .QUEUE_FLUSH, .FETCH_ADDR, .IN_SEQ, .ACTIVE_VEC);
  cits_mem_mdl cits_mem_mdl_inst (.CLK, .RSTN, .dly, .MEM_REQ, .MEM_WR, .MEM_ADDR,
    .MEM_WDATA, .MEM_ACK, .MEM_RDATA);
  // 125 MHz clock
  initial forever #4 CLK = ~CLK;
  // ----------------------
  // Shared tasks
  // ----------------------
  task automatic tally_and_finish;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One boundary {sti,irq_return_instr,pop_flags_instr,cli}, wait for quiet, compare state
  task automatic bnd(input logic [3:0] q, input logic s, input logic [7:0] v, o,
    input logic [71:0] e);
    int k;
    @(posedge CLK);
    {INSTR_STI, INSTR_IRQ_RETURN_INSTR, INSTR_POP_FLAGS_INSTR, INSTR_CLI} <= q;
    {SOFT_REQ, SOFT_VEC, OPCODE, INSTR_DONE} <= {s, v, o, 1'b1};
    @(posedge CLK);
    {INSTR_STI, INSTR_IRQ_RETURN_INSTR, INSTR_POP_FLAGS_INSTR, INSTR_CLI, SOFT_REQ, INSTR_DONE} <= 6'h00;
    k = 0;
    for (int i = 0; i < 300 && k < 4; i++)
    begin
      @(negedge CLK);
      k = IN_SEQ ? 0 : k + 1;
    end
    `CK("state", e, st)
  endtask
  task automatic nmi;
    @(posedge CLK);
    NMI_REQ <= 1'b1;
    @(posedge CLK);
    NMI_REQ <= 1'b0;
  endtask
  // ----------------------
  // Scenarios
  // ----------------------
  task automatic t_reset;
    RSTN <= 1'b0;
    repeat (6) @(posedge CLK);
    `CK("rst", 113'h0_0000_ffff_0000_0000_0000_0000_0000, {IN_SEQ, FLAGS, CODE_SEGMENT_REG,
      INSTRUCTION_POINTER_REG, DATA_SEGMENT_REG, STACK_SEGMENT_REG, EXTRA_SEGMENT_REG, STACK_PTR})
    `CK("fetch", 21'h1ffff0, {QUEUE_FLUSH, FETCH_ADDR})
    RSTN <= 1'b1;
  endtask
  task automatic t_nest;
    bnd(4'h0, 1'b1, 8'h21, 8'hcd, 72'h0000_21_1084_1086_fffa);
    `CK("push", 48'h0000_ffff_0000, {cits_mem_mdl_inst.mem[20'h0fffe],
      cits_mem_mdl_inst.mem[20'h0fffc], cits_mem_mdl_inst.mem[20'h0fffa]})
    bnd(4'h0, 1'b1, 8'h22, 8'hcd, 72'h0000_22_1088_108a_fff4);
    bnd(4'h4, 1'b0, 8'h00, 8'h90, 72'h0000_22_1084_1086_fffa);
    bnd(4'h4, 1'b0, 8'h00, 8'h90, 72'h0000_22_0000_ffff_0000);
  endtask
  task automatic t_step;
    POP_FLAGS_INSTR_DATA <= 16'h0100;
    dly <= 4'h0;
    bnd(4'h2, 1'b0, 8'h00, 8'h9d, 72'h0100_22_0000_ffff_0000);
    bnd(4'h0, 1'b0, 8'h00, 8'h90, 72'h0000_01_1004_1006_fffa);
    bnd(4'h4, 1'b0, 8'h00, 8'h90, 72'h0100_01_0000_ffff_0000);
    bnd(4'h0, 1'b1, 8'h40, 8'hcd, 72'h0000_01_1004_1006_fff4);
    `CK("nest", 32'h1102_1100, {cits_mem_mdl_inst.mem[20'h0fff6],
      cits_mem_mdl_inst.mem[20'h0fff4]})
    bnd(4'h4, 1'b0, 8'h00, 8'h90, 72'h0000_01_1100_1102_fffa);
  endtask
  task automatic t_ext;
    dly <= 4'h9;
    nmi();
    bnd(4'h0, 1'b0, 8'h00, 8'h90, 72'h0000_02_1008_100a_fff4);
    bnd(4'h4, 1'b0, 8'h00, 8'h90, 72'h0000_02_1100_1102_fffa);
    {MASKABLE_REQUEST, MASKABLE_REQUEST_VEC} <= {1'b1, 8'h50};
    bnd(4'h8, 1'b0, 8'h00, 8'hfb, 72'h0200_02_1100_1102_fffa);
    bnd(4'h0, 1'b0, 8'h00, 8'h90, 72'h0000_50_1140_1142_fff4);
    MASKABLE_REQUEST <= 1'b0;
    bnd(4'h4, 1'b0, 8'h00, 8'h90, 72'h0200_50_1100_1102_fffa);
    nmi();
    bnd(4'h0, 1'b1, 8'h77, 8'hcc, 72'h0000_03_100c_100e_fff4);
    bnd(4'h0, 1'b0, 8'h00, 8'h90, 72'h0000_02_1008_100a_ffee);
  endtask
  // Entry cut short by reset
  task automatic t_halt;
    @(posedge CLK);
    {SOFT_REQ, INSTR_DONE} <= 2'b11;
    @(posedge CLK);
    {SOFT_REQ, INSTR_DONE} <= 2'b00;
    repeat (3) @(posedge CLK);
    t_reset();
  endtask
  initial
  begin
    t_reset();
    t_nest();
    t_step();
    t_ext();
    t_halt();
    tally_and_finish();
  end
  // Watchdog
  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule
